// file: sar_pkg.sv
/*
  shared constants and pin bundle for the converter sequencing and
  serial readout block.
  assumes a 40 MHz core clock; all pins arrive asynchronously.
*/
package sar_pkg;

  ////////////////////////////////////////////////////////////////////////
  // resolution and timing
  localparam int SAR_BITS = 18;
  localparam int CLK_PERIOD_NS = 25;
  // longest conversion time, rounded down to whole cycles
  localparam int CONV_MAX_NS = 1500;
  localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
  // cycles given to each approximation step
  localparam int STEP_CYC = CONV_MAX_CYC / SAR_BITS;

  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [SAR_BITS-1:0] RESULT_RST = 18'h00000;
  localparam logic SDO_OE_RST = 1'b0;
  localparam logic BUSY_RST = 1'b0;
  localparam logic NAP_RST = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // pin bundle as seen after synchronisation
  typedef struct packed {
    logic convert_strobe;
    logic sck;
    logic readout_enable_or_cascade_in;
    logic cascade_select;
  } sar_pins_t;

  // shared pin resets to its disabled level: no output burst after reset
  localparam sar_pins_t PINS_RST = 4'h2;

  typedef enum logic {
    SAR_ACQUIRE,
    SAR_CONVERT
  } sar_state_t;

endpackage

// file: sar_readout.sv
/*
  conversion sequencer, successive approximation register and serial
  readout shifter of an 18-bit converter.
  assumes: all pins (convert strobe, serial clock, shared pin, cascade
  select) are asynchronous to core_clk and are synchronised here; the
  comparator decision comes from analog logic settled on core_clk.
*/
module sar_readout
  import sar_pkg::*;
#(
  parameter int RES_BITS = SAR_BITS,
  parameter int STEP_CYCLES = STEP_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic convert_strobe,
  input wire logic sck,
  input wire logic readout_enable_or_cascade_in,
  input wire logic cascade_select,
  input wire logic comp_keep,
  output logic [RES_BITS-1:0] sampling_capacitor_dac,
  output logic busy,
  output logic nap,
  output logic sdo,
  output logic sdo_oe
);

  ////////////////////////////////////////////////////////////////////////
  // parameter checks
  localparam int IDX_W = $clog2(RES_BITS);
  localparam int CNT_W = $clog2(STEP_CYCLES + 1);
  localparam logic [IDX_W-1:0] IDX_TOP = IDX_W'(RES_BITS - 1);
  localparam logic [IDX_W-1:0] IDX_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STEP_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [IDX_W-1:0] IDX_ONE = IDX_W'(1);

  if (RES_BITS < 2) begin : g_bad_bits
    $error("sar_readout: RES_BITS must be at least 2");
  end
  if (STEP_CYCLES < 1) begin : g_bad_step
    $error("sar_readout: STEP_CYCLES must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  sar_pins_t pins_raw;
  sar_pins_t pins_meta;
  sar_pins_t pins_sync;
  sar_pins_t pins_prev;

  assign pins_raw.convert_strobe = convert_strobe;
  assign pins_raw.sck = sck;
  assign pins_raw.readout_enable_or_cascade_in = readout_enable_or_cascade_in;
  assign pins_raw.cascade_select = cascade_select;

  // first stage feeds only the second: no logic on metastable bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_meta <= PINS_RST;
      pins_sync <= PINS_RST;
      pins_prev <= PINS_RST;
    end else begin
      pins_meta <= pins_raw;
      pins_sync <= pins_meta;
      pins_prev <= pins_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // edge and mode decode
  wire logic strobe_rise;
  wire logic sck_rise;
  wire logic chain_mode;
  wire logic shared_pin;

  assign strobe_rise = pins_sync.convert_strobe & ~pins_prev.convert_strobe;
  assign sck_rise = pins_sync.sck & ~pins_prev.sck;
  assign chain_mode = pins_sync.cascade_select;
  assign shared_pin = pins_sync.readout_enable_or_cascade_in;

  ////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  sar_state_t state;
  sar_state_t next_state;
  logic [CNT_W-1:0] step_cnt;
  logic [CNT_W-1:0] next_step_cnt;
  logic [IDX_W-1:0] bit_idx;
  logic [IDX_W-1:0] next_bit_idx;

  wire logic in_convert;
  wire logic start_conv;
  wire logic step_done;
  wire logic last_bit;
  wire logic conv_end;

  assign in_convert = (state == SAR_CONVERT);
  assign start_conv = (state == SAR_ACQUIRE) & strobe_rise;
  // step pace from the core clock
  assign step_done = in_convert & (step_cnt == CNT_LAST);
  assign last_bit = (bit_idx == IDX_ZERO);
  assign conv_end = step_done & last_bit;

  always_comb begin
    next_state = state;
    unique case (state)
      SAR_ACQUIRE: begin
        if (strobe_rise) begin
          next_state = SAR_CONVERT;
        end
      end
      SAR_CONVERT: begin
        if (conv_end) begin
          next_state = SAR_ACQUIRE;
        end
      end
    endcase
  end

  assign next_step_cnt = (start_conv | step_done) ? CNT_ZERO :
                         in_convert ? step_cnt + CNT_ONE : step_cnt;

  assign next_bit_idx = start_conv ? IDX_TOP :
                        (step_done & ~last_bit) ? bit_idx - IDX_ONE : bit_idx;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SAR_ACQUIRE;
      step_cnt <= CNT_ZERO;
      bit_idx <= IDX_TOP;
    end else begin
      state <= next_state;
      step_cnt <= next_step_cnt;
      bit_idx <= next_bit_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // approximation register, one slice per bit
  logic [RES_BITS-1:0] next_dac;

  for (genvar i = 0; i < RES_BITS; i++) begin : g_sar_bit
    localparam logic [IDX_W-1:0] ME = IDX_W'(i);
    localparam logic START_VAL = (i == RES_BITS - 1);
    wire logic decide_me;
    wire logic trial_me;

    assign decide_me = step_done & (bit_idx == ME);
    assign trial_me = step_done & ~last_bit & (bit_idx - IDX_ONE == ME);
    // keep or drop the trial bit, then try the next weight
    assign next_dac[i] = start_conv ? START_VAL :
                         decide_me ? comp_keep :
                         trial_me ? 1'b1 : sampling_capacitor_dac[i];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sampling_capacitor_dac <= RESULT_RST;
    end else begin
      sampling_capacitor_dac <= next_dac;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result coding
  wire logic [RES_BITS-1:0] result_word;

  // offset binary to two's complement by msb flip
  assign result_word = {~next_dac[RES_BITS-1], next_dac[RES_BITS-2:0]};

  ////////////////////////////////////////////////////////////////////////
  // status outputs
  wire logic next_busy;
  wire logic next_nap;

  assign next_busy = (next_state == SAR_CONVERT);
  assign next_nap = (next_state == SAR_ACQUIRE);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= BUSY_RST;
      nap <= NAP_RST;
    end else begin
      busy <= next_busy;
      nap <= next_nap;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial readout shifter
  logic [RES_BITS-1:0] shreg;
  logic [RES_BITS-1:0] next_shreg;
  wire logic shift_in;
  wire logic do_shift;
  wire logic next_sdo_oe;

  // chain mode takes upstream bits from the shared pin
  assign shift_in = chain_mode ? shared_pin : 1'b0;
  // edges during conversion are ignored, the host keeps them quiet
  assign do_shift = sck_rise & ~in_convert & sdo_oe;

  // load the word at conversion end
  // shift msb first on each rising serial clock while sdo_oe is set
  // own bits leave first, upstream bits follow
  assign next_shreg = conv_end ? result_word :
                      do_shift ? {shreg[RES_BITS-2:0], shift_in} : shreg;

  // normal mode: shared pin gates the output
  assign next_sdo_oe = chain_mode | ~shared_pin;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg <= RESULT_RST;
      sdo_oe <= SDO_OE_RST;
    end else begin
      shreg <= next_shreg;
      sdo_oe <= next_sdo_oe;
    end
  end

  // msb is on the pin in the same edge that clears busy
  assign sdo = shreg[RES_BITS-1];

endmodule // sar_readout

// file: sar_readout_chk.sv
/* assertions on the sequencer and serial readout ports.
   assumes it is bound into every sar_readout instance. */
module sar_readout_chk
  import sar_pkg::*;
#(
  parameter int RES_BITS = SAR_BITS,
  parameter int STEP_CYCLES = STEP_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic convert_strobe,
  input wire logic sck,
  input wire logic readout_enable_or_cascade_in,
  input wire logic cascade_select,
  input wire logic [RES_BITS-1:0] sampling_capacitor_dac,
  input wire logic busy,
  input wire logic nap,
  input wire logic sdo,
  input wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CONV = RES_BITS * STEP_CYCLES;
  logic [7:0] busy_len;
  logic [7:0] next_busy_len;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////
  // length of the current busy run
  assign next_busy_len = busy ? busy_len + 8'h01 : 8'h00;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) busy_len <= 8'h00;
    else busy_len <= next_busy_len;
  // pins must settle through the synchronisers first
  sequence en_on;
    !cascade_select && !readout_enable_or_cascade_in;
  endsequence
  sequence en_off;
    !cascade_select && readout_enable_or_cascade_in;
  endsequence
  //////////////////////////////////////////////////////////////////////
  chk_nap_busy: assert property
    (nap != busy) else $error("nap not inverse of busy");
  chk_busy_len: assert property
    ($fell(busy) |-> busy_len == 8'(CONV)) else $error("busy length");
  chk_first_trial: assert property
    ($rose(busy) |-> sampling_capacitor_dac == {1'b1, {(RES_BITS-1){1'b0}}})
    else $error("first trial word");
  chk_start_cause: assert property
    ($rose(busy) |-> $past(convert_strobe, 2)) else $error("busy uncaused");
  chk_msb_ready: assert property
    ($fell(busy) |-> sdo != $past(sampling_capacitor_dac[RES_BITS-1]))
    else $error("first bit not ready");
  chk_hold_busy: assert property
    (busy && $past(busy) |-> $stable(sdo)) else $error("shift while busy");
  chk_shift_cause: assert property
    ($changed(sdo) |-> $fell(busy) || ($past(sck, 2) && !$past(sck, 5)))
    else $error("sdo moved without clock");
  chk_oe_on: assert property
    (en_on [*4] |-> sdo_oe) else $error("output not driven");
  chk_oe_off: assert property
    (en_off [*4] |-> !sdo_oe) else $error("output not released");
endmodule // sar_readout_chk

bind sar_readout sar_readout_chk #(
  .RES_BITS(RES_BITS),
  .STEP_CYCLES(STEP_CYCLES)
) chk (
  .core_clk(core_clk), .rst_n(rst_n), .convert_strobe(convert_strobe),
  .sck(sck), .readout_enable_or_cascade_in(readout_enable_or_cascade_in),
  .cascade_select(cascade_select), .busy(busy), .nap(nap), .sdo(sdo),
  .sampling_capacitor_dac(sampling_capacitor_dac), .sdo_oe(sdo_oe)
);

// file: sar_host.sv
/* host model: strobes a conversion, waits it out, clocks words out.
   assumes the bench calls its tasks just after a core_clk edge. */
module sar_host
  import sar_pkg::*;
(
  input wire logic core_clk,
  input wire logic busy,
  input wire logic sdo_line,
  input wire logic chain,
  input wire logic en_n,
  input wire logic [SAR_BITS-1:0] up_word,
  output logic convert_strobe = 1'b0,
  output logic sck = 1'b0,
  output logic shared_pin,
  output logic [2*SAR_BITS-1:0] got = '0,
  output logic got_stb = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic up_bit = 1'b0;
  assign shared_pin = chain ? up_bit : en_n;
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic convert();
    int i;
    convert_strobe = 1'b1;
    tick(4);
    convert_strobe = 1'b0;
    for (i = 0; i < 2 * CONV_MAX_CYC && busy !== 1'b0; i++) tick(1);
  endtask
  // sample each bit, with one rising clock between bits and none after the last
  task automatic read(input int n, input bit report);
    int i;
    got = '0;
    for (i = n - 1; i >= 0; i--) begin
      got[i] = sdo_line;
      if (i > 0) begin
        up_bit = (i >= n - SAR_BITS) ? up_word[i - n + SAR_BITS] : 1'b0;
        tick(1);
        sck = 1'b1;
        tick(4);
        sck = 1'b0;
        tick(4);
      end
    end
    got_stb = report;
    tick(1);
    got_stb = 1'b0;
  endtask
endmodule // sar_host

// file: sar_readout_bench.sv
/* bench for sar_readout with host and comparator models.
   assumes the checker is bound in by its own file. */
module sar_readout_bench
  import sar_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cascade_select = 1'b0;
  logic en_n = 1'b0;
  logic [SAR_BITS-1:0] up_word = '0;
  logic [SAR_BITS-1:0] target = '0;
  logic [SAR_BITS-1:0] dac;
  logic [2*SAR_BITS-1:0] got;
  logic [2*SAR_BITS-1:0] exp_q[$];
  logic convert_strobe, sck, shared_pin, busy, nap, sdo, sdo_oe, got_stb;
  logic last_sdo = 1'b0;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  // comparator keeps a trial that does not exceed the sample
  wire comp_keep = dac <= target;
  // a released line shows the inverse of its last level
  wire sdo_line = sdo_oe ? sdo : !last_sdo;
  always #12.5 core_clk = !core_clk;
  always @(posedge core_clk) if (sdo_oe === 1'b1) last_sdo <= sdo;
  sar_readout uut (
    .core_clk(core_clk), .rst_n(rst_n), .convert_strobe(convert_strobe),
    .sck(sck), .readout_enable_or_cascade_in(shared_pin),
    .cascade_select(cascade_select), .comp_keep(comp_keep),
    .sampling_capacitor_dac(dac), .busy(busy), .nap(nap), .sdo(sdo),
    .sdo_oe(sdo_oe)
  );
  sar_host host (
    .core_clk(core_clk), .busy(busy), .sdo_line(sdo_line),
    .chain(cascade_select), .en_n(en_n), .up_word(up_word),
    .convert_strobe(convert_strobe), .sck(sck), .shared_pin(shared_pin),
    .got(got), .got_stb(got_stb)
  );
  //////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [2*SAR_BITS-1:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // each word read with report set is matched with the oldest note
  always @(posedge got_stb) cmp(exp_q.pop_front(), got);
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  // stray clocks while released must not shift the word
  task automatic run(input logic [SAR_BITS-1:0] t, input int n, bit stray);
    target = t;
    exp_q.push_back(n > SAR_BITS ? {t ^ 18'h20000, up_word} :
                    {18'h00000, t ^ 18'h20000});
    host.convert();
    // a wait that ran out leaves busy high and counts here
    cmp(36'h1, {34'h0, busy, nap});
    if (stray) begin
      en_n = 1'b1;
      host.tick(5);
      cmp(36'h0, {35'h0, sdo_oe});
      host.read(4, 0);
      en_n = 1'b0;
      host.tick(5);
      cmp(36'h1, {35'h0, sdo_oe});
    end
    host.read(n, 1);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    i = $urandom(32'h6364);
    repeat (6) @(posedge core_clk);
    #2 rst_n = 1'b1;
    host.tick(4);
    run(18'h1FFFF, SAR_BITS, 0);
    run(18'h20000, SAR_BITS, 0);
    for (i = 0; i < 3; i++) run(SAR_BITS'($urandom), SAR_BITS, 0);
    run(SAR_BITS'($urandom), SAR_BITS, 1);
    cascade_select = 1'b1;
    up_word = SAR_BITS'($urandom);
    run(SAR_BITS'($urandom), 2 * SAR_BITS, 0);
    host.tick(5);
    end_of_test();
  end
endmodule // sar_readout_bench
